// File: rtl/secc_engine.sv
/*
 * Serial burst error detection and correction engine with a classic Wishbone register slave.
 * Assumes serial inputs and gen/shift strobes are driven from logic on clk_i; clear_all_n_i
 * may be asynchronous and is synchronised here.
 */
`timescale 1ns/1ps

module secc_engine (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial channel and strobes
    input wire logic clear_all_n_i,
    input wire logic freeze_state_i,
    input wire logic transmit_gen_shift_i,
    input wire logic receive_gen_shift_i,
    input wire logic correction_gen_shift_i,
    input wire logic tx_serial_in_i,
    input wire logic rx_serial_in_i,
    input wire logic correction_serial_in_i,
    output logic tx_serial_out_o,
    output logic rx_side_serial_out_o,
    // Flags and timing
    output logic syndrome_nonzero_flag_o,
    output logic burst_located_flag_o,
    output logic correction_done_flag_o,
    output logic delayed_clock_out_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    secc_pkg::secc_cfg_t cfg_reg;
    secc_pkg::secc_flags_t flag_reg;
    secc_pkg::secc_state_t state_reg;
    secc_pkg::secc_state_t state_next;
    logic [31:0] shreg_reg;
    logic [31:0] shreg_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [3:0] eoc_cnt_reg;
    logic tx_out_reg;
    logic tx_out_next;
    logic rx_out_reg;
    logic rx_out_next;
    logic clr_meta_reg;
    logic clr_sync_reg;
    logic soft_clear_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] rd_data;
    logic dclk_reg;
    logic clear_now;
    logic crc;
    logic msb;
    logic [4:0] span;
    logic [31:0] span_mask;
    logic [31:0] residue;
    logic [31:0] rev_val;
    logic set_err;
    logic set_burst_located_flag;
    logic bus_req;

    // Burst must end on bit 0, else the clock count would not give the displacement
    function automatic logic fits(input logic [31:0] r, input logic [31:0] m);
        return r[0] && ((r & ~m) == 32'h0000_0000);
    endfunction

    // ************************************************************
    // Clear and configuration decode
    // ************************************************************
    // The pin may be asynchronous; only the second stage is used, so a runt pulse is either
    // caught whole or missed, never half applied.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clr_meta_reg <= 1'b1;
            clr_sync_reg <= 1'b1;
        end else begin
            clr_meta_reg <= clear_all_n_i;
            clr_sync_reg <= clr_meta_reg;
        end
    end

    assign clear_now = rst_i | ~clr_sync_reg | soft_clear_reg;
    assign crc = cfg_reg.poly_select;
    assign residue = crc ? secc_pkg::SECC_CRC_RESIDUE : secc_pkg::SECC_ECC_RESIDUE;
    assign msb = crc ? shreg_reg[secc_pkg::SECC_CRC_MSB] : shreg_reg[secc_pkg::SECC_ECC_MSB];
    assign rev_val = secc_pkg::secc_rev_step(shreg_reg);

    always_comb begin
        // Reserved 1/0 code falls back to the smallest span
        span = secc_pkg::SECC_SPAN_5;
        span_mask = secc_pkg::SECC_MASK_5;
        if (cfg_reg.span_select_0 && cfg_reg.span_select_1) begin
            span = secc_pkg::SECC_SPAN_11;
            span_mask = secc_pkg::SECC_MASK_11;
        end else if (!cfg_reg.span_select_0 && cfg_reg.span_select_1) begin
            span = secc_pkg::SECC_SPAN_8;
            span_mask = secc_pkg::SECC_MASK_8;
        end
    end

    // ************************************************************
    // Engine next state
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        shreg_next = shreg_reg;
        cnt_next = cnt_reg;
        tx_out_next = tx_out_reg;
        rx_out_next = rx_out_reg;
        set_err = 1'b0;
        set_burst_located_flag = 1'b0;
        if (freeze_state_i) begin
            tx_out_next = tx_serial_in_i;
        end else begin
            unique case (state_reg)
                secc_pkg::SECC_ST_INIT: begin
                    if (!cfg_reg.direction_select && transmit_gen_shift_i) begin
                        state_next = secc_pkg::SECC_ST_TX;
                        shreg_next = secc_pkg::secc_fwd_step(shreg_reg, tx_serial_in_i, crc);
                        rx_out_next = tx_serial_in_i;
                    end else if (cfg_reg.direction_select && receive_gen_shift_i) begin
                        state_next = secc_pkg::SECC_ST_RX;
                        shreg_next = secc_pkg::secc_fwd_step(shreg_reg, rx_serial_in_i, crc);
                        tx_out_next = rx_serial_in_i;
                    end
                end
                secc_pkg::SECC_ST_TX: begin
                    if (transmit_gen_shift_i) begin
                        shreg_next = secc_pkg::secc_fwd_step(shreg_reg, tx_serial_in_i, crc);
                        rx_out_next = tx_serial_in_i;
                    end else begin
                        // Zeros shift in behind; the inverted checkbits go out and the host stops after the checkbit count
                        rx_out_next = ~msb;
                        shreg_next = crc ? ({shreg_reg[30:0], 1'b0} & secc_pkg::SECC_CRC_MASK)
                                         : {shreg_reg[30:0], 1'b0};
                    end
                end
                secc_pkg::SECC_ST_RX: begin
                    if (receive_gen_shift_i) begin
                        shreg_next = secc_pkg::secc_fwd_step(shreg_reg, rx_serial_in_i, crc);
                        tx_out_next = rx_serial_in_i;
                    end else begin
                        shreg_next = shreg_reg ^ residue;
                        set_err = (shreg_reg ^ residue) != 32'h0000_0000;
                        state_next = secc_pkg::SECC_ST_POST;
                    end
                end
                secc_pkg::SECC_ST_POST: begin
                    if (!correction_gen_shift_i) begin
                        tx_out_next = msb;
                        shreg_next = crc ? ({shreg_reg[30:0], 1'b0} & secc_pkg::SECC_CRC_MASK)
                                         : {shreg_reg[30:0], 1'b0};
                    end else if (!crc && flag_reg.syndrome_nonzero_flag) begin
                        // Preparation clock also tests the unshifted syndrome (displacement zero)
                        tx_out_next = correction_serial_in_i;
                        state_next = secc_pkg::SECC_ST_SEARCH;
                        if (fits(shreg_reg, span_mask)) begin
                            set_burst_located_flag = 1'b1;
                            state_next = secc_pkg::SECC_ST_BURST_LOCATED_FLAG;
                            tx_out_next = correction_serial_in_i ^ shreg_reg[0];
                            cnt_next = 4'h1;
                        end
                    end
                end
                secc_pkg::SECC_ST_SEARCH: begin
                    tx_out_next = correction_serial_in_i;
                    if (correction_gen_shift_i) begin
                        shreg_next = rev_val;
                        if (fits(rev_val, span_mask)) begin
                            set_burst_located_flag = 1'b1;
                            state_next = secc_pkg::SECC_ST_BURST_LOCATED_FLAG;
                            tx_out_next = correction_serial_in_i ^ rev_val[0];
                            cnt_next = 4'h1;
                        end
                    end
                end
                secc_pkg::SECC_ST_BURST_LOCATED_FLAG: begin
                    if (correction_gen_shift_i) begin
                        tx_out_next = correction_serial_in_i;
                        if (5'(cnt_reg) < span) begin
                            tx_out_next = correction_serial_in_i ^ shreg_reg[cnt_reg];
                            cnt_next = cnt_reg + 4'h1;
                        end
                    end else begin
                        // Pattern leaves top of window first, so short bursts lead with zeros
                        tx_out_next = shreg_reg[span - 5'h01];
                        shreg_next = {shreg_reg[30:0], 1'b0} & span_mask;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Engine registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (clear_now) begin
            state_reg <= secc_pkg::SECC_ST_INIT;
            shreg_reg <= secc_pkg::SECC_PRESET;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            shreg_reg <= shreg_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (clear_now) begin
            tx_out_reg <= 1'b0;
            rx_out_reg <= 1'b0;
            dclk_reg <= 1'b0;
        end else begin
            tx_out_reg <= tx_out_next;
            rx_out_reg <= rx_out_next;
            dclk_reg <= 1'b1;
        end
    end

    // ************************************************************
    // Flags
    // ************************************************************
    // Clear wins here: an init discards any event of the same cycle by design
    always_ff @(posedge clk_i) begin
        if (clear_now) begin
            flag_reg <= '0;
            eoc_cnt_reg <= 4'h0;
        end else begin
            if (set_err) begin
                flag_reg.syndrome_nonzero_flag <= 1'b1;
            end
            if (set_burst_located_flag) begin
                flag_reg.burst_located_flag <= 1'b1;
            end
            if (flag_reg.burst_located_flag && !flag_reg.correction_done_flag && !freeze_state_i) begin
                eoc_cnt_reg <= eoc_cnt_reg + 4'h1;
                if (eoc_cnt_reg == secc_pkg::SECC_EOC_DELAY - 4'h1) begin
                    flag_reg.correction_done_flag <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    assign bus_req = wb_cyc_i & wb_stb_i;

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            secc_pkg::SECC_ADDR_CTRL: rd_data = {28'h000_0000, cfg_reg};
            secc_pkg::SECC_ADDR_STATUS: rd_data = {18'h0_0000, state_reg, 5'h00, flag_reg};
            secc_pkg::SECC_ADDR_SYNDROME: rd_data = shreg_reg;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Writes land on the edge where the master sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
            cfg_reg <= secc_pkg::SECC_CTRL_RESET;
            soft_clear_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            soft_clear_reg <= 1'b0;
            if (bus_req && !ack_reg) begin
                dat_reg <= rd_data;
            end
            if (bus_req && ack_reg && wb_we_i && wb_sel_i[0] && wb_adr_i == secc_pkg::SECC_ADDR_CTRL) begin
                cfg_reg <= wb_dat_i[3:0];
                soft_clear_reg <= wb_dat_i[secc_pkg::SECC_CTRL_CLEAR_BIT];
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign tx_serial_out_o = tx_out_reg;
    assign rx_side_serial_out_o = rx_out_reg;
    assign syndrome_nonzero_flag_o = flag_reg.syndrome_nonzero_flag;
    assign burst_located_flag_o = flag_reg.burst_located_flag;
    assign correction_done_flag_o = flag_reg.correction_done_flag;
    assign delayed_clock_out_o = dclk_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_ERR_STICKY: assert property (@(posedge clk_i) disable iff (clear_now)
        flag_reg.syndrome_nonzero_flag |=> flag_reg.syndrome_nonzero_flag)
        else $error("syndrome flag dropped without clear");

    AST_BURST_LOCATED_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (clear_now)
        flag_reg.burst_located_flag |=> flag_reg.burst_located_flag)
        else $error("burst located flag dropped without clear");

    AST_EOC_LATE: assert property (@(posedge clk_i) disable iff (clear_now)
        $rose(flag_reg.correction_done_flag) |-> $past(flag_reg.burst_located_flag, 11))
        else $error("correction done came too soon");

    AST_EOC_NOT_EARLY: assert property (@(posedge clk_i) disable iff (clear_now)
        $rose(flag_reg.burst_located_flag) |-> !flag_reg.correction_done_flag [*8])
        else $error("correction done rose with located flag");

    AST_FREEZE_PASS: assert property (@(posedge clk_i) disable iff (clear_now)
        freeze_state_i |=> tx_serial_out_o == $past(tx_serial_in_i))
        else $error("frozen tx output not passing input");

    AST_FREEZE_HOLD: assert property (@(posedge clk_i) disable iff (clear_now)
        freeze_state_i |=> $stable(shreg_reg) && $stable(state_reg) && $stable(flag_reg))
        else $error("state moved while frozen");

    AST_CRC_NO_SEARCH: assert property (@(posedge clk_i) disable iff (clear_now)
        (state_reg == secc_pkg::SECC_ST_POST && crc)
        |=> state_reg != secc_pkg::SECC_ST_SEARCH && state_reg != secc_pkg::SECC_ST_BURST_LOCATED_FLAG)
        else $error("CRC mode entered search");

    AST_INIT_WAIT: assert property (@(posedge clk_i) disable iff (clear_now)
        (state_reg == secc_pkg::SECC_ST_INIT && !transmit_gen_shift_i && !receive_gen_shift_i)
        |=> state_reg == secc_pkg::SECC_ST_INIT && shreg_reg == secc_pkg::SECC_PRESET)
        else $error("left initial state without gen strobe");

    AST_TX_ECHO: assert property (@(posedge clk_i) disable iff (clear_now)
        (state_reg == secc_pkg::SECC_ST_TX && transmit_gen_shift_i && !freeze_state_i)
        |=> rx_side_serial_out_o == $past(tx_serial_in_i))
        else $error("transmit data not echoed");

    AST_TX_INVERT: assert property (@(posedge clk_i) disable iff (clear_now)
        (state_reg == secc_pkg::SECC_ST_TX && !transmit_gen_shift_i && !freeze_state_i && !crc)
        |=> rx_side_serial_out_o == !$past(shreg_reg[secc_pkg::SECC_ECC_MSB]))
        else $error("checkbit not inverted");

    AST_RX_LATCH: assert property (@(posedge clk_i) disable iff (clear_now)
        (state_reg == secc_pkg::SECC_ST_RX && !receive_gen_shift_i && !freeze_state_i)
        |=> state_reg == secc_pkg::SECC_ST_POST
            && flag_reg.syndrome_nonzero_flag == (shreg_reg != 32'h0000_0000))
        else $error("error flag not latched on receive end");

    AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");

endmodule // secc_engine

// File: rtl/secc_pkg.sv
/*
 * Constants, carrier types and polynomial helpers for the serial burst ECC/CRC engine.
 * Assumes the engine and its bench refer to every name as secc_pkg::name.
 */
package secc_pkg;

    // ************************************************************
    // Polynomials and widths
    // ************************************************************
    localparam logic [31:0] SECC_ECC_POLY = 32'h140A_0445;
    localparam logic [31:0] SECC_CRC_POLY = 32'h0000_1021;
    localparam logic [31:0] SECC_CRC_MASK = 32'h0000_FFFF;
    localparam logic [31:0] SECC_PRESET = 32'hFFFF_FFFF;
    localparam int SECC_ECC_BITS = 32;
    localparam int SECC_CRC_BITS = 16;
    localparam int SECC_ECC_MSB = 31;
    localparam int SECC_CRC_MSB = 15;

    // ************************************************************
    // Correction spans
    // ************************************************************
    localparam logic [4:0] SECC_SPAN_5 = 5'h05;
    localparam logic [4:0] SECC_SPAN_8 = 5'h08;
    localparam logic [4:0] SECC_SPAN_11 = 5'h0B;
    localparam logic [31:0] SECC_MASK_5 = 32'h0000_001F;
    localparam logic [31:0] SECC_MASK_8 = 32'h0000_00FF;
    localparam logic [31:0] SECC_MASK_11 = 32'h0000_07FF;
    localparam logic [3:0] SECC_EOC_DELAY = 4'hB;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] SECC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SECC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] SECC_ADDR_SYNDROME = 8'h08;
    localparam int SECC_CTRL_CLEAR_BIT = 4;
    localparam int SECC_STATUS_STATE_LSB = 8;
    localparam logic [3:0] SECC_CTRL_RESET = 4'h0;

    typedef struct packed {
        logic direction_select;
        logic span_select_1;
        logic span_select_0;
        logic poly_select;
    } secc_cfg_t;

    typedef struct packed {
        logic correction_done_flag;
        logic burst_located_flag;
        logic syndrome_nonzero_flag;
    } secc_flags_t;

    typedef enum logic [5:0] {
        SECC_ST_INIT = 6'b00_0001,
        SECC_ST_TX = 6'b00_0010,
        SECC_ST_RX = 6'b00_0100,
        SECC_ST_POST = 6'b00_1000,
        SECC_ST_SEARCH = 6'b01_0000,
        SECC_ST_BURST_LOCATED_FLAG = 6'b10_0000
    } secc_state_t;

    // ************************************************************
    // Division steps
    // ************************************************************
    function automatic logic [31:0] secc_fwd_step(input logic [31:0] r, input logic din, input logic crc);
        logic fb;
        logic [31:0] s;
        fb = din ^ (crc ? r[SECC_CRC_MSB] : r[SECC_ECC_MSB]);
        s = {r[30:0], 1'b0};
        if (crc) begin
            s = s & SECC_CRC_MASK;
        end
        if (fb) begin
            s = s ^ (crc ? SECC_CRC_POLY : SECC_ECC_POLY);
        end
        return s;
    endfunction

    // Inverse of one zero-input forward step: multiplies by x^-1 modulo the ECC generator
    function automatic logic [31:0] secc_rev_step(input logic [31:0] r);
        logic [31:0] s;
        s = {1'b0, r[31:1]};
        if (r[0]) begin
            s = {1'b1, r[31:1] ^ SECC_ECC_POLY[31:1]};
        end
        return s;
    endfunction

    // Remainder left over by inverted checkbits; removed so good data gives a zero syndrome
    function automatic logic [31:0] secc_residue(input logic crc);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < (crc ? SECC_CRC_BITS : SECC_ECC_BITS); i++) begin
            r = secc_fwd_step(r, 1'b1, crc);
        end
        return r;
    endfunction

    localparam logic [31:0] SECC_ECC_RESIDUE = secc_residue(1'b0);
    localparam logic [31:0] SECC_CRC_RESIDUE = secc_residue(1'b1);

endpackage

// File: dv/secc_chan.sv
/* Channel model: replays a stored record onto the receive pins with its gen strobe.
   Assumes the bench loads the record and length no later than the edge that raises play_i. */
`timescale 1ns/1ps
module secc_chan (
    // Control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic play_i,
    input wire logic [63:0] rec_i,
    input wire logic [6:0] len_i,
    // Serial line
    output logic ser_o,
    output logic gen_o
);
    logic [6:0] idx_reg;
    // A released line toggles, so a stale bit never passes for data
    always_ff @(posedge clk_i) begin
        gen_o <= !rst_i && play_i && idx_reg < len_i;
        ser_o <= (play_i && idx_reg < len_i) ? rec_i[idx_reg[5:0]] : !rst_i && !ser_o;
        idx_reg <= (rst_i || !play_i) ? 7'h00 : idx_reg + 7'(idx_reg < len_i);
    end
endmodule // secc_chan

// File: dv/tb.sv
/* Bench: register bus, transmit, receive, search and freeze.
   Assumes secc_chan drives the receive and correction serial inputs. */
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, clr_n = 1'b1, frz = 1'b0;
    logic transmit_gen_shift = 1'b0, cgs = 1'b0, tx_in = 1'b0, play = 1'b0, mon = 1'b0, src = 1'b0, last = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, q, q_o;
    logic [63:0] rec = 64'h0;
    logic [6:0] len = 7'h00;
    logic ack, tx_out, rx_out, syn, located, finished, dclk, ser, gen;
    int mismatches = 0, comparisons = 0;
    initial forever #10 clk_i = ~clk_i;
    secc_chan i_chan (.clk_i, .rst_i, .play_i(play), .rec_i(rec), .len_i(len), .ser_o(ser), .gen_o(gen));
    secc_engine i_dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q_o), .wb_ack_o(ack), .clear_all_n_i(clr_n),
        .freeze_state_i(frz), .transmit_gen_shift_i(transmit_gen_shift), .receive_gen_shift_i(gen),
        .correction_gen_shift_i(cgs), .tx_serial_in_i(tx_in), .rx_serial_in_i(ser),
        .correction_serial_in_i(ser), .tx_serial_out_o(tx_out), .rx_side_serial_out_o(rx_out),
        .syndrome_nonzero_flag_o(syn), .burst_located_flag_o(located), .correction_done_flag_o(finished),
        .delayed_clock_out_o(dclk));
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = q_o;
        req <= 1'b0;
        if (ack !== 1'b1) begin
            mismatches++;
            test_done;
        end
    endtask
    // Data bits, then the inverted remainder most significant bit first
    function automatic logic [63:0] exp_rec(input logic [63:0] d, input int n, input logic crc);
        logic [31:0] r;
        logic [63:0] o;
        int w;
        w = crc ? 16 : 32;
        r = crc ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        o = d & ((64'h1 << n) - 64'h1);
        for (int i = 0; i < n; i++)
            r = ((r << 1) & (crc ? 32'h0000_FFFF : 32'hFFFF_FFFF))
                ^ ((d[i] ^ r[w - 1]) ? (crc ? secc_pkg::SECC_CRC_POLY : secc_pkg::SECC_ECC_POLY) : 32'h0);
        for (int j = 0; j < w; j++)
            o[n + j] = ~r[w - 1 - j];
        return o;
    endfunction
    task automatic clr;
        @(posedge clk_i);
        clr_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        clr_n <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(64'({syn, located, finished}), 64'h0);
    endtask
    task automatic tx(input int n, input int w, output logic [63:0] d, output logic [63:0] s);
        logic b;
        for (int i = 0; i <= n + w; i++) begin
            b = 1'($urandom);
            @(posedge clk_i);
            transmit_gen_shift <= (i < n);
            tx_in <= b;
            if (i < n) d[i] = b;
            @(negedge clk_i);
            if (i > 0) s[i - 1] = rx_out;
        end
    endtask
    // Search is raised on the edge after the strobe falls, before the syndrome can shift
    task automatic rx(input logic [63:0] r, input int n, input logic srch);
        @(posedge clk_i);
        play <= 1'b1;
        rec <= r;
        len <= 7'(n);
        src <= 1'b1;
        repeat (2) @(posedge clk_i);
        mon <= 1'b1;
        repeat (n) @(posedge clk_i);
        mon <= 1'b0;
        cgs <= srch;
        repeat (2) @(posedge clk_i);
        play <= 1'b0;
        chk(64'(dclk), 64'h1);
    endtask
    always @(negedge clk_i) begin
        if (mon) chk(64'(tx_out), 64'(last));
        last = src ? ser : tx_in;
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        test_done;
    end
    initial begin
        logic [63:0] d, s, r, p;
        logic [3:0] cfg;
        int n, w, k, sp;
        k = $urandom(32'hd80e_979a);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, secc_pkg::SECC_ADDR_CTRL, 32'h0);
        chk(64'(q), 64'h0);
        wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h0C, 32'h0);
        chk(64'(q), 64'h0);
        wb(1'b0, secc_pkg::SECC_ADDR_STATUS, 32'h0);
        chk(64'(q), 64'h0000_0100);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            cfg = m == 0 ? 4'h0 : m == 1 ? 4'h4 : m == 2 ? 4'h6 : 4'h1;
            w = m == 3 ? 16 : 32;
            n = 8 + int'($urandom % 25);
            wb(1'b1, secc_pkg::SECC_ADDR_CTRL, 32'(cfg));
            clr();
            tx(n, w, d, s);
            r = exp_rec(d, n, m == 3);
            chk(s & ((64'h1 << (n + w)) - 64'h1), r);
            wb(1'b1, secc_pkg::SECC_ADDR_CTRL, 32'(cfg | 4'h8));
            clr();
            rx(r, n + w, 1'b0);
            chk(64'(syn), 64'h0);
            clr();
            rx(r ^ (64'h1 << ($urandom % (n + w))), n + w, 1'b1);
            chk(64'(syn), 64'h1);
            k = 0;
            while (located !== 1'b1 && k < 100) begin
                @(negedge clk_i);
                k++;
            end
            chk(64'(located), 64'(m != 3));
            if (m != 3) begin
                repeat (10) @(negedge clk_i);
                chk(64'(finished), 64'h0);
                @(negedge clk_i);
                chk(64'({syn, located, finished}), 64'h7);
            end
            @(posedge clk_i);
            cgs <= 1'b0;
            // Single-bit burst: pattern leaves as span-1 zeros, then a one
            p = 64'h0;
            sp = m == 0 ? 5 : m == 1 ? 8 : 11;
            @(posedge clk_i);
            for (int i = 0; i < sp && m != 3; i++) begin
                @(negedge clk_i);
                p = {p[62:0], tx_out};
            end
            chk(p, 64'(m != 3));
            $display("test mode %0d done", m);
        end
        wb(1'b1, secc_pkg::SECC_ADDR_CTRL, 32'h0);
        clr();
        @(posedge clk_i);
        src <= 1'b0;
        frz <= 1'b1;
        transmit_gen_shift <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            tx_in <= 1'($urandom);
            mon <= (i > 0);
            @(posedge clk_i);
        end
        mon <= 1'b0;
        wb(1'b0, secc_pkg::SECC_ADDR_STATUS, 32'h0);
        chk(64'(q[13:8]), 64'h1);
        frz <= 1'b0;
        transmit_gen_shift <= 1'b0;
        $display("test freeze done");
        test_done;
    end
endmodule // tb
